// ==== shared/bbrx_defines.vh ====
/*
 Constants for the baseband receive and auxiliary converter port:
 register offsets, field positions, reset values and timing counts.
 Assumes a 250 MHz system clock (4 ns period).
*/
`ifndef BBRX_DEFINES_VH
`define BBRX_DEFINES_VH

// System clock period in ps
`define BBRX_CLK_PS 4000
// Chip-rate x8 clock period, ps (101.6 ns)
`define BBRX_CHIP_RATE_X8_CLOCK_PS 101600
// Half period in cycles, rounded down (12 cycles), not clamped
`define BBRX_CHIP_RATE_X8_CLOCK_HALF ((`BBRX_CHIP_RATE_X8_CLOCK_PS / 2) / `BBRX_CLK_PS)
// Calibration time in us
`define BBRX_CAL_US 26000
// Calibration cycles
`define BBRX_CAL_CYC ((`BBRX_CAL_US * 1000) / (`BBRX_CLK_PS / 1000))
// Aux serial clock high and low, ps
`define BBRX_AUX_HI_PS 810000
`define BBRX_AUX_LO_PS 1620000
`define BBRX_AUX_HI_CYC (`BBRX_AUX_HI_PS / `BBRX_CLK_PS)
`define BBRX_AUX_LO_CYC (`BBRX_AUX_LO_PS / `BBRX_CLK_PS)
// Data valid before aux clock rise, ps (1 us)
`define BBRX_AUX_SETUP_PS 1000000
`define BBRX_AUX_SETUP_CYC (`BBRX_AUX_SETUP_PS / `BBRX_CLK_PS)
// Aux conversion time (inside 40 us limit), cycles
`define BBRX_AUX_CONV_CYC 2000
// Minimum request high time, ns, and cycles rounded up
`define BBRX_AUX_REQ_NS 100
`define BBRX_AUX_REQ_CYC ((`BBRX_AUX_REQ_NS * 1000 + `BBRX_CLK_PS - 1) / `BBRX_CLK_PS)

// Register byte offsets
`define BBRX_REG_CTRL 8'h00
`define BBRX_REG_STATUS 8'h04
`define BBRX_REG_TRIM 8'h08
`define BBRX_REG_AUX 8'h0C
`define BBRX_REG_CAL_IN 8'h10
// Control fields
`define BBRX_CTRL_CDMA 0
`define BBRX_CTRL_MXS 1
`define BBRX_CTRL_SEL_LO 2
`define BBRX_CTRL_RECAL 4
`define BBRX_CTRL_RESET 32'h00000000
// Status fields
`define BBRX_ST_CAL 0
`define BBRX_ST_AUXBUSY 1
`define BBRX_ST_DONE 2

`endif

// ==== design/bbrx_shift8.v ====
/*
 Eight-bit MSB-first load/shift register shared by the serial outputs.
 Assumes load and shift come from the same clock domain.
*/
`timescale 1ns/1ps
module bbrx_shift8
(
    // Clock and reset
    input wire sys_clk_i,
    input wire reset_i,
    // Control
    input wire load_i,
    input wire [7:0] data_i,
    input wire shift_i,
    // Serial bit
    output reg bit_o
);
    reg [7:0] sreg; // Holding word

    // Load or shift, MSB leaves first
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            sreg <= 8'h00;
            bit_o <= 1'b0;
        end
        else if (load_i)
        begin
            sreg <= {data_i[6:0], 1'b0};
            bit_o <= data_i[7];
        end
        else if (shift_i)
        begin
            sreg <= {sreg[6:0], 1'b0};
            bit_o <= sreg[7];
        end
    end
endmodule

// ==== design/bbrx_port.v ====
/*
 Baseband receive and auxiliary converter port, digital side.
 Assumes converter results arrive as parallel words already sampled,
 and the processor's FM clock and strobe are asynchronous pins.
*/
`timescale 1ns/1ps
`include "bbrx_defines.vh"
module bbrx_port
#(
    parameter CAL_CYC = `BBRX_CAL_CYC,
    parameter AUX_CONV_CYC = `BBRX_AUX_CONV_CYC
)
(
    // Clock and reset
    input wire sys_clk_i,
    input wire reset_i,
    // AXI4-Lite slave
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Converter results (same domain)
    input wire [3:0] cdma_i_code_i,
    input wire [3:0] cdma_q_code_i,
    input wire [7:0] fm_i_code_i,
    input wire [7:0] fm_q_code_i,
    input wire [7:0] aux_code_i,
    input wire cal_pass_gt_i,
    // Processor pins
    input wire fm_sample_clock_i,
    input wire fm_receive_strobe_i,
    input wire aux_convert_request_i,
    input wire aux_channel_sel_low_i,
    input wire aux_channel_sel_high_i,
    // CDMA outputs
    output reg [3:0] rx_inphase_sample_bus_o,
    output reg [3:0] rx_quadrature_sample_bus_o,
    output reg chip_rate_x8_clock_o,
    // Calibration outputs
    output reg cal_active_o,
    output reg test_tone_high_o,
    output reg [7:0] inphase_cutoff_trim_dac_o,
    output reg [7:0] quadrature_cutoff_trim_dac_o,
    output reg [7:0] gain_balance_trim_dac_o,
    // FM outputs
    output reg fm_inphase_serial_word_o,
    output reg fm_quadrature_serial_word_o,
    output reg fm_sample_o,
    // Aux outputs
    output reg [1:0] aux_mux_sel_o,
    output reg aux_power_o,
    output reg aux_sample_o,
    output reg aux_serial_clock_o,
    output reg aux_serial_output_o
);
    localparam HALF = `BBRX_CHIP_RATE_X8_CLOCK_HALF;
    // Calibration states
    localparam C_IDLE = 2'b00;
    localparam C_RUN = 2'b01;
    localparam C_DONE = 2'b10;
    // Aux states
    localparam A_IDLE = 3'b000;
    localparam A_CONV = 3'b001;
    localparam A_LOW = 3'b010;
    localparam A_HIGH = 3'b011;
    localparam A_WAIT = 3'b100;

    reg [31:0] ctrl; // Software control word
    reg [2:0] fck_s, stb_s, req_s, sel_s0, sel_s1; // Pin synchronisers
    reg [1:0] sel_q; // Synchronised channel pins
    reg cdma_q; // Previous mode
    reg [7:0] div_cnt; // Chip-rate divider
    reg [1:0] cstate;
    reg [31:0] cal_cnt;
    reg [1:0] trim_idx; // Which DAC is searched
    reg [2:0] bit_idx; // Bit under trial
    reg [7:0] fm_cnt; // FM bit counter
    reg fm_busy;
    reg [2:0] astate;
    reg [31:0] a_cnt;
    reg [3:0] a_bits;
    reg [7:0] req_hi; // Request high-time counter
    wire cdma = ctrl[`BBRX_CTRL_CDMA];
    wire fck_fall = fck_s[2] & ~fck_s[1];
    wire fm_load, fm_shift, a_load, a_shift;
    wire fmi_bit, fmq_bit, aux_bit;

    // Bit trial mask for the SAR step
    function [7:0] sar_mask;
        input [2:0] b;
        sar_mask = 8'h01 << b;
    endfunction

    // Synchronise all processor pins through three flops
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            fck_s <= 3'h0;
            stb_s <= 3'h0;
            req_s <= 3'h0;
            sel_s0 <= 3'h0;
            sel_s1 <= 3'h0;
        end
        else
        begin
            fck_s <= {fck_s[1:0], fm_sample_clock_i};
            stb_s <= {stb_s[1:0], fm_receive_strobe_i};
            req_s <= {req_s[1:0], aux_convert_request_i};
            sel_s0 <= {sel_s0[1:0], aux_channel_sel_low_i};
            sel_s1 <= {sel_s1[1:0], aux_channel_sel_high_i};
        end
    end

    // Chip-rate clock divider and sample bus
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            div_cnt <= 8'h00;
            chip_rate_x8_clock_o <= 1'b0;
            rx_inphase_sample_bus_o <= 4'h0;
            rx_quadrature_sample_bus_o <= 4'h0;
        end
        else if (div_cnt == HALF - 1)
        begin
            div_cnt <= 8'h00;
            chip_rate_x8_clock_o <= ~chip_rate_x8_clock_o;
            if (chip_rate_x8_clock_o && cdma)
            begin
                rx_inphase_sample_bus_o <= cdma_i_code_i;
                rx_quadrature_sample_bus_o <= cdma_q_code_i;
            end
        end
        else
            div_cnt <= div_cnt + 8'h01;
    end

    // Calibration sequencer; balance first, then I and Q cutoff
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            cdma_q <= 1'b0;
            cstate <= C_IDLE;
            cal_cnt <= 32'h0;
            trim_idx <= 2'h0;
            bit_idx <= 3'h7;
            cal_active_o <= 1'b0;
            test_tone_high_o <= 1'b0;
            inphase_cutoff_trim_dac_o <= 8'h80;
            quadrature_cutoff_trim_dac_o <= 8'h80;
            gain_balance_trim_dac_o <= 8'h80;
        end
        else
        begin
            cdma_q <= cdma;
            case (cstate)
                C_IDLE, C_DONE:
                    if ((cdma && !cdma_q) || (cdma && ctrl[`BBRX_CTRL_RECAL]))
                    begin
                        cstate <= C_RUN;
                        cal_cnt <= 32'h0;
                        trim_idx <= 2'h0;
                        bit_idx <= 3'h7;
                        cal_active_o <= 1'b1;
                        test_tone_high_o <= 1'b0;
                        gain_balance_trim_dac_o <= 8'h80;
                        inphase_cutoff_trim_dac_o <= 8'h80;
                        quadrature_cutoff_trim_dac_o <= 8'h80;
                    end
                C_RUN:
                begin
                    cal_cnt <= cal_cnt + 32'h1;
                    if (cal_cnt == CAL_CYC - 1)
                    begin
                        cstate <= C_DONE;
                        cal_active_o <= 1'b0;
                        test_tone_high_o <= 1'b0;
                    end
                    else if (cal_cnt[11:0] == 12'hFFF && trim_idx != 2'h3)
                    begin
                        case (trim_idx)
                            2'h0: gain_balance_trim_dac_o <=
                                (gain_balance_trim_dac_o
                                 & ~(cal_pass_gt_i ? 8'h00 : sar_mask(bit_idx)))
                                | (bit_idx != 3'h0 ? sar_mask(bit_idx - 3'h1)
                                   : 8'h00);
                            2'h1: inphase_cutoff_trim_dac_o <=
                                (inphase_cutoff_trim_dac_o
                                 & ~(cal_pass_gt_i ? 8'h00 : sar_mask(bit_idx)))
                                | (bit_idx != 3'h0 ? sar_mask(bit_idx - 3'h1)
                                   : 8'h00);
                            default: quadrature_cutoff_trim_dac_o <=
                                (quadrature_cutoff_trim_dac_o
                                 & ~(cal_pass_gt_i ? 8'h00 : sar_mask(bit_idx)))
                                | (bit_idx != 3'h0 ? sar_mask(bit_idx - 3'h1)
                                   : 8'h00);
                        endcase
                        bit_idx <= bit_idx - 3'h1;
                        if (bit_idx == 3'h0)
                        begin
                            trim_idx <= trim_idx + 2'h1;
                            // Tone moves to transition band after balance
                            test_tone_high_o <= 1'b1;
                        end
                    end
                end
                default: cstate <= C_IDLE;
            endcase
        end
    end

    // Strobe sampled at FM clock fall
    assign fm_load = fck_fall && stb_s[2] && !cdma && !fm_busy;
    assign fm_shift = fck_fall && fm_busy;
    // FM path uses trims as left by CDMA

    // FM word framing
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            fm_busy <= 1'b0;
            fm_cnt <= 8'h00;
            fm_sample_o <= 1'b0;
            fm_inphase_serial_word_o <= 1'b0;
            fm_quadrature_serial_word_o <= 1'b0;
        end
        else
        begin
            fm_sample_o <= fm_load;
            if (fm_load)
            begin
                fm_busy <= 1'b1;
                fm_cnt <= 8'h00;
            end
            else if (fm_shift)
            begin
                fm_cnt <= fm_cnt + 8'h01;
                if (fm_cnt == 8'h07)
                    fm_busy <= 1'b0;
            end
            fm_inphase_serial_word_o <= fm_busy & fmi_bit;
            fm_quadrature_serial_word_o <= fm_busy & fmq_bit;
        end
    end

    bbrx_shift8 u_fmi
    (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .load_i(fm_load),
        .data_i(fm_i_code_i),
        .shift_i(fm_shift),
        .bit_o(fmi_bit)
    );
    bbrx_shift8 u_fmq
    (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .load_i(fm_load),
        .data_i(fm_q_code_i),
        .shift_i(fm_shift),
        .bit_o(fmq_bit)
    );

    assign a_load = (astate == A_CONV) && (a_cnt == AUX_CONV_CYC - 1);
    assign a_shift = (astate == A_HIGH) && (a_cnt == `BBRX_AUX_HI_CYC - 1);

    // Aux converter: request, convert, shift eight bits
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            astate <= A_IDLE;
            a_cnt <= 32'h0;
            a_bits <= 4'h0;
            req_hi <= 8'h00;
            sel_q <= 2'h0;
            aux_mux_sel_o <= 2'h0;
            aux_power_o <= 1'b0;
            aux_sample_o <= 1'b0;
            aux_serial_clock_o <= 1'b0;
            aux_serial_output_o <= 1'b0;
        end
        else
        begin
            sel_q <= {sel_s1[2], sel_s0[2]};
            aux_mux_sel_o <= ctrl[`BBRX_CTRL_MXS]
                ? ctrl[`BBRX_CTRL_SEL_LO+1:`BBRX_CTRL_SEL_LO] : sel_q;
            aux_sample_o <= a_load;
            req_hi <= req_s[2] ? (req_hi == 8'hFF ? req_hi : req_hi + 8'h01)
                               : 8'h00;
            case (astate)
                A_IDLE:
                begin
                    aux_power_o <= 1'b0;
                    aux_serial_clock_o <= 1'b0;
                    aux_serial_output_o <= 1'b0;
                    if (req_hi == `BBRX_AUX_REQ_CYC)
                    begin
                        astate <= A_CONV;
                        a_cnt <= 32'h0;
                        aux_power_o <= 1'b1;
                    end
                end
                A_CONV:
                begin
                    a_cnt <= a_cnt + 32'h1;
                    if (a_load)
                    begin
                        astate <= A_LOW;
                        a_cnt <= 32'h0;
                        a_bits <= 4'h0;
                    end
                end
                // Low phase, data leads rise by setup less one cycle
                A_LOW:
                begin
                    a_cnt <= a_cnt + 32'h1;
                    if (a_cnt == `BBRX_AUX_LO_CYC - `BBRX_AUX_SETUP_CYC)
                        aux_serial_output_o <= aux_bit;
                    if (a_cnt == `BBRX_AUX_LO_CYC - 1)
                    begin
                        astate <= A_HIGH;
                        a_cnt <= 32'h0;
                        aux_serial_clock_o <= 1'b1;
                    end
                end
                A_HIGH:
                begin
                    a_cnt <= a_cnt + 32'h1;
                    if (a_shift)
                    begin
                        a_cnt <= 32'h0;
                        aux_serial_clock_o <= 1'b0;
                        a_bits <= a_bits + 4'h1;
                        astate <= (a_bits == 4'h7) ? A_WAIT : A_LOW;
                    end
                end
                // Wait for request release before re-arming
                A_WAIT:
                begin
                    aux_serial_output_o <= 1'b0;
                    aux_power_o <= 1'b0;
                    if (!req_s[2])
                        astate <= A_IDLE;
                end
                default: astate <= A_IDLE;
            endcase
        end
    end

    bbrx_shift8 u_aux
    (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .load_i(a_load),
        .data_i(aux_code_i),
        .shift_i(a_shift),
        .bit_o(aux_bit)
    );

    // AXI4-Lite: one access each way, both halves taken together
    always @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            ctrl <= `BBRX_CTRL_RESET;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h0;
        end
        else
        begin
            // Re-trigger bit is self-clearing
            ctrl[`BBRX_CTRL_RECAL] <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
            if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
                && !s_axi_awready)
            begin
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'b00;
                if (s_axi_awaddr == `BBRX_REG_CTRL)
                begin
                    if (s_axi_wstrb[0])
                        ctrl[7:0] <= s_axi_wdata[7:0];
                end
                else
                    s_axi_bresp <= 2'b10;
            end
            if (s_axi_arvalid && !s_axi_rvalid && !s_axi_arready)
            begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                case (s_axi_araddr)
                    `BBRX_REG_CTRL: s_axi_rdata <= {24'h0, ctrl[7:0]};
                    `BBRX_REG_STATUS: s_axi_rdata <= {29'h0,
                        cstate == C_DONE, astate != A_IDLE, cal_active_o};
                    `BBRX_REG_TRIM: s_axi_rdata <= {8'h00,
                        gain_balance_trim_dac_o,
                        quadrature_cutoff_trim_dac_o,
                        inphase_cutoff_trim_dac_o};
                    `BBRX_REG_AUX: s_axi_rdata <= {22'h0, aux_mux_sel_o,
                        aux_code_i};
                    default:
                    begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end
        end
    end
endmodule

// ==== verification/bbrx_port_assertions.sv ====
/* Checker bound onto bbrx_port: calibration, sample and aux timing.
   Assumes one clock domain with synchronous active-high reset. */
`timescale 1ns/1ps
module bbrx_chk
(
    // Clock and reset
    input wire sys_clk_i,
    input wire reset_i,
    // CDMA and calibration outputs
    input wire [3:0] rx_inphase_sample_bus_o,
    input wire [3:0] rx_quadrature_sample_bus_o,
    input wire chip_rate_x8_clock_o,
    input wire cal_active_o,
    input wire test_tone_high_o,
    input wire [7:0] inphase_cutoff_trim_dac_o,
    input wire [7:0] quadrature_cutoff_trim_dac_o,
    input wire [7:0] gain_balance_trim_dac_o,
    // FM and aux outputs
    input wire fm_sample_o,
    input wire aux_power_o,
    input wire aux_serial_clock_o,
    input wire aux_serial_output_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);
    // Short names for grouped outputs
    wire [23:0] trims = {gain_balance_trim_dac_o,
        quadrature_cutoff_trim_dac_o, inphase_cutoff_trim_dac_o};
    wire [7:0] bus = {rx_inphase_sample_bus_o, rx_quadrature_sample_bus_o};
    wire chip = chip_rate_x8_clock_o;
    wire aclk = aux_serial_clock_o;
    wire adat = aux_serial_output_o;
    AST_TRIM_HOLD: assert property (
        !cal_active_o && !$past(cal_active_o) |-> $stable(trims))
        else $error("trim code moved outside calibration");
    AST_TONE_OFF: assert property (
        !cal_active_o |-> !test_tone_high_o)
        else $error("test tone left on after calibration");
    AST_CHIP_HIGH: assert property (
        $fell(chip) |-> $past(chip, 12) && !$past(chip, 13))
        else $error("chip clock high time not 12 cycles");
    AST_BUS_AT_FALL: assert property (
        $changed(bus) |-> !chip && ($past(chip) || $past(chip, 2)))
        else $error("sample bus moved away from clock fall");
    AST_AUX_IDLE: assert property (
        !aux_power_o |-> !aclk && !adat)
        else $error("aux outputs not low while idle");
    AST_AUX_HIGH: assert property (
        $rose(aclk) |-> ##202 $fell(aclk))
        else $error("aux clock high time wrong");
    AST_AUX_SETUP: assert property (
        $rose(aclk) |-> adat == $past(adat, 200))
        else $error("aux data not settled before clock rise");
    AST_FM_PULSE: assert property (
        fm_sample_o |=> !fm_sample_o)
        else $error("FM sample strobe longer than one cycle");
endmodule
bind bbrx_port bbrx_chk u_chk (.*);

// ==== verification/bbrx_dsp_model.sv ====
/* Processor-side model: FM link clock, strobe, aux request and
   capture of serial words. Time based, apart from the system clock. */
`timescale 1ns/1ps
module bbrx_dsp_model
(
    // Serial outputs of the port
    input wire fm_i_bit_i,
    input wire fm_q_bit_i,
    input wire aux_clk_i,
    input wire aux_dat_i,
    // Pins driven by the processor
    output reg fm_clk_o = 0,
    output reg strobe_o = 0,
    output reg request_o = 0
);
    // Captured words and bit counter
    logic [7:0] got_i, got_q, got_aux;
    int aux_rises = 0;
    logic idle_low;
    always @(posedge aux_clk_i)
    begin
        got_aux = {got_aux[6:0], aux_dat_i};
        aux_rises++;
    end
    // framed link clock
    // Clock stands low between frames; strobe spans the first fall
    task automatic fm_frame();
        idle_low = 1;
        #13 fm_clk_o = 1;
        strobe_o = 1;
        for (int k = 0; k < 10; k++)
        begin
            #40 fm_clk_o = 0;
            #40 fm_clk_o = 1;
            strobe_o = 0;
            // Bits read mid-bit, then idle level
            if (k < 8)
            begin
                got_i = {got_i[6:0], fm_i_bit_i};
                got_q = {got_q[6:0], fm_q_bit_i};
            end
            else
                idle_low &= !fm_i_bit_i && !fm_q_bit_i;
        end
        #40 fm_clk_o = 0;
    endtask
    // request held 200 ns, then a gap
    task automatic aux_request();
        request_o = 1;
        #200 request_o = 0;
        #40;
    endtask
endmodule

// ==== verification/tb_top.sv ====
/* Self-checking bench for bbrx_port: bus reads and writes, CDMA
   calibration, FM frames and aux conversions via bbrx_dsp_model. */
`timescale 1ns/1ps
module tb_top;
    // Shortened calibration, still long enough for the full search
    localparam int CAL = 98400;
    logic sys_clk_i = 0;
    logic reset_i = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_rvalid;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    // Converter codes and select pins
    logic [3:0] cdma_i_code_i = 0, cdma_q_code_i = 0;
    logic [7:0] fm_i_code_i = 0, fm_q_code_i = 0, aux_code_i = 0;
    logic cal_pass_gt_i = 1;
    logic aux_channel_sel_low_i = 0, aux_channel_sel_high_i = 0;
    wire fm_sample_clock_i, fm_receive_strobe_i, aux_convert_request_i;
    // Design outputs
    wire [3:0] rx_inphase_sample_bus_o, rx_quadrature_sample_bus_o;
    wire chip_rate_x8_clock_o, cal_active_o, test_tone_high_o;
    wire [7:0] inphase_cutoff_trim_dac_o, quadrature_cutoff_trim_dac_o;
    wire [7:0] gain_balance_trim_dac_o;
    wire fm_inphase_serial_word_o, fm_quadrature_serial_word_o, fm_sample_o;
    wire [1:0] aux_mux_sel_o;
    wire aux_power_o, aux_sample_o, aux_serial_clock_o, aux_serial_output_o;
    wire [7:0] bus = {rx_inphase_sample_bus_o, rx_quadrature_sample_bus_o};
    // Counters and model state
    int bad_count = 0;
    int n_checks = 0;
    int t;
    logic [1:0] sel, exp_mux;
    logic [15:0] exp_q[$];

    // 250 MHz system clock
    initial
    begin
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    bbrx_port #(.CAL_CYC(CAL), .AUX_CONV_CYC(100)) uut (.*);

    bbrx_dsp_model dsp
    (
        .fm_i_bit_i(fm_inphase_serial_word_o),
        .fm_q_bit_i(fm_quadrature_serial_word_o),
        .aux_clk_i(aux_serial_clock_o),
        .aux_dat_i(aux_serial_output_o),
        .fm_clk_o(fm_sample_clock_i),
        .strobe_o(fm_receive_strobe_i),
        .request_o(aux_convert_request_i)
    );

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Write: both channels offered at once, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do
        begin
            @(posedge sys_clk_i);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
    endtask

    // Read and compare data and response
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
        input logic [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do
        begin
            @(posedge sys_clk_i);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        chk(s_axi_rdata, e);
        chk(32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 0;
        @(posedge sys_clk_i);
    endtask

    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        void'($urandom(32'h0098));
        repeat (20) @(posedge sys_clk_i);
        reset_i <= 0;
        repeat (3) @(posedge sys_clk_i);
        rchk(8'h08, 32'h00808080, 2'b00);
        rchk(8'h14, 32'h0, 2'b10);
        cdma_i_code_i <= 4'($urandom);
        cdma_q_code_i <= 4'($urandom);
        wr(8'h00, 32'h1);
        rchk(8'h04, 32'h1, 2'b00);
        for (t = 0; t < CAL + 50 && cal_active_o; t++)
            @(posedge sys_clk_i);
        chk(32'(t > CAL - 50 && t < CAL + 50), 1);
        chk(32'({cal_active_o, test_tone_high_o}), 0);
        rchk(8'h04, 32'h4, 2'b00);
        rchk(8'h08, 32'h00FFFFFF, 2'b00);
        cal_pass_gt_i <= 0;
        repeat (40) @(posedge sys_clk_i);
        chk(32'(bus), 32'({cdma_i_code_i, cdma_q_code_i}));
        // FM frames back to back
        wr(8'h00, 32'h0);
        repeat (2)
        begin
            fm_i_code_i <= 8'($urandom);
            fm_q_code_i <= 8'($urandom);
            @(posedge sys_clk_i);
            exp_q.push_back({fm_i_code_i, fm_q_code_i});
            dsp.fm_frame();
            chk(32'({dsp.got_i, dsp.got_q}), 32'(exp_q.pop_front()));
            chk(32'(dsp.idle_low), 1);
        end
        rchk(8'h08, 32'h00FFFFFF, 2'b00);
        // Aux: pin select, then register select
        for (int m = 0; m < 2; m++)
        begin
            sel = 2'($urandom);
            aux_code_i <= 8'($urandom);
            {aux_channel_sel_high_i, aux_channel_sel_low_i} <= 2'($urandom);
            wr(8'h00, m ? {28'h0, sel, 2'b10} : 32'h0);
            exp_mux = m ? sel : {aux_channel_sel_high_i, aux_channel_sel_low_i};
            dsp.aux_rises = 0;
            dsp.aux_request();
            chk(32'(aux_mux_sel_o), 32'(exp_mux));
            dsp.aux_request();
            for (t = 100; t < 10000 && aux_power_o; t++)
                @(posedge sys_clk_i);
            chk(32'(t < 10000), 1);
            chk(32'(dsp.got_aux), 32'(aux_code_i));
            chk(32'(dsp.aux_rises), 8);
            chk(32'({aux_serial_clock_o, aux_serial_output_o}), 0);
        end
        close_out();
    end

    // Watchdog over the whole run
    initial
    begin
        #((CAL + 20000) * 4);
        bad_count++;
        close_out();
    end
endmodule
